// ===== design/crc_regs.sv
// Programmable CRC generator: AXI4-Lite registers, input FIFO, control.
// Assumes idle_mode comes from processor logic on aclk.
//
// Overview of operation
// - Module off clears FIFO, data, result, engine
// - Idle halt select suspends operation in Idle
// - Word count tracks valid FIFO words
// - FIFO limit 8 or 16 by polynomial length
// - Full flag set while FIFO full
// - Empty flag set while FIFO empty
// - Select 1: interrupt when FIFO empties
// - Select 0: interrupt when shifting completes
// - Run bit starts and stops the shifter
// - LSb first when lsb select set
// - MSb first when lsb select clear
// - Width field is datum width minus one
// - Length field is polynomial length minus one
// - Low taps 15..1 add XOR terms
// - Unimplemented bits ignore writes, read zero
// - Shifting starts only with run and words
// - Two bits shifted per clock
// - Count increments when datum MSb written
// - Zero-order term always XORed
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "crc_map.svh"
module crc_regs #(
  parameter int FIFO_DEPTH = 16  // Words in the input FIFO
) (
  input  wire logic        aclk,           // Clock, 100 MHz
  input  wire logic        aresetn,        // Sync reset, low
  input  wire logic [7:0]  s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [7:0]  s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready,   // Read data ready
  input  wire logic        idle_mode,      // Processor in Idle
  output logic             crc_irq         // Interrupt pulse
);
  if (FIFO_DEPTH != 16) begin : g_bad_depth
    $error("FIFO_DEPTH must be 16");
  end

  // ==========================================================
  // Declarations
  logic        crc_module_on;       // Module enable
  logic        idle_halt_select;    // Stop in Idle
  logic        irq_source_select;   // Interrupt source
  logic        shifter_run;         // Shifter started
  logic        lsb_first_select;    // Shift direction
  logic [4:0]  datum_width_minus1;  // Datum width - 1
  logic [4:0]  poly_length_minus1;  // Poly length - 1
  logic [15:1] taps_low;            // Terms 15..1
  logic [15:0] taps_high;           // Terms 31..16
  logic [15:0] data_lo;             // Input data low half
  logic [15:0] data_hi;             // Input data high half
  logic [4:0]  fifo_word_count;     // Valid FIFO words
  logic [3:0]  wr_ptr;              // FIFO write pointer
  logic [3:0]  rd_ptr;              // FIFO read pointer
  logic [31:0] fifo_mem [FIFO_DEPTH];  // FIFO storage
  logic        worked;              // Data shifted since start
  logic        aw_held;             // Address captured
  logic        w_held;              // Data captured
  logic [7:0]  wr_addr;             // Captured address
  logic [31:0] wr_data;             // Captured data
  logic [3:0]  wr_strb;             // Captured strobes
  logic        wr_fire;             // Register write now
  logic        fifo_full_flag;      // FIFO full
  logic        fifo_empty_flag;     // FIFO empty
  logic        halted;              // Idle suspension
  logic        push_req;            // MSb half written
  logic        push_ok;             // Word enters FIFO
  logic [31:0] push_word;           // Word to store
  logic        pop;                 // Word to engine
  logic        done_evt;            // Calculation finished
  logic        eng_busy;            // Engine buffer busy
  logic [31:0] crc_value;           // Engine result
  logic [15:0] ctl_view;            // Control readback
  logic [15:0] ctl_new;             // Control after write
  logic [15:0] half_new;            // Write data per half
  logic [1:0]  seed_we;             // Result half writes
  crc_pkg::crc_cfg_t cfg;           // Engine configuration

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction : merge16

  // FIFO word limit per polynomial length
  function automatic logic [4:0] fifo_limit(input logic [4:0] plen);
    fifo_limit = (plen > `CRC_SMALL_PLEN) ? `CRC_LIMIT_LARGE : `CRC_LIMIT_SMALL;
  endfunction : fifo_limit

  // Mapped register check
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= `CRC_OFS_RES_HI);
  endfunction : is_mapped

  // ==========================================================
  // Status and decode
  always_comb begin
    fifo_full_flag  = (fifo_word_count >= fifo_limit(poly_length_minus1));
    fifo_empty_flag = (fifo_word_count == 5'h00);
    halted   = idle_halt_select && idle_mode;
    ctl_view = 16'h0000;  // Unimplemented bits read zero
    ctl_view[`CRC_BIT_ON]   = crc_module_on;
    ctl_view[`CRC_BIT_IDLE] = idle_halt_select;
    ctl_view[`CRC_POS_COUNT +: 5] = fifo_word_count;
    ctl_view[`CRC_BIT_FULL]  = fifo_full_flag;
    ctl_view[`CRC_BIT_EMPTY] = fifo_empty_flag;
    ctl_view[`CRC_BIT_ISEL]  = irq_source_select;
    ctl_view[`CRC_BIT_RUN]   = shifter_run;
    ctl_view[`CRC_BIT_LSB]   = lsb_first_select;
    wr_fire  = aw_held && w_held && !s_axi_bvalid;
    half_new = wr_data[15:0];
    ctl_new  = merge16(ctl_view, half_new, wr_strb[1:0]);
    push_req = wr_fire && ((wr_addr == `CRC_OFS_DATA_LO && datum_width_minus1 <= `CRC_HALF_MSB)
             || (wr_addr == `CRC_OFS_DATA_HI && datum_width_minus1 > `CRC_HALF_MSB));
    push_ok  = push_req && crc_module_on && !fifo_full_flag;
    push_word = (wr_addr == `CRC_OFS_DATA_LO) ? {16'h0000, merge16(data_lo, half_new, wr_strb[1:0])}
              : {merge16(data_hi, half_new, wr_strb[1:0]), data_lo};
    pop      = crc_module_on && shifter_run && !halted && !fifo_empty_flag && !eng_busy;
    done_evt = crc_module_on && shifter_run && worked && fifo_empty_flag && !eng_busy;
    seed_we  = {wr_fire && wr_addr == `CRC_OFS_RES_HI, wr_fire && wr_addr == `CRC_OFS_RES_LO};
    cfg.lsb_first = lsb_first_select;
    cfg.width_m1  = datum_width_minus1;
    cfg.plen_m1   = poly_length_minus1;
    cfg.poly      = {taps_high, taps_low, 1'b1};
  end

  // ==========================================================
  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      wr_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Ready flags and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CRC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid && !wr_fire;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid && !wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(wr_addr) ? `CRC_RESP_OKAY : `CRC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CRC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= is_mapped(s_axi_araddr) ? `CRC_RESP_OKAY : `CRC_RESP_SLVERR;
      case (s_axi_araddr)
        `CRC_OFS_CONTROL: s_axi_rdata <= {16'h0000, ctl_view};
        `CRC_OFS_WIDTH:   s_axi_rdata <= {19'h00000, datum_width_minus1, 3'h0, poly_length_minus1};
        `CRC_OFS_TAPS_LO: s_axi_rdata <= {16'h0000, taps_low, 1'b0};
        `CRC_OFS_TAPS_HI: s_axi_rdata <= {16'h0000, taps_high};
        `CRC_OFS_DATA_LO: s_axi_rdata <= {16'h0000, data_lo};
        `CRC_OFS_DATA_HI: s_axi_rdata <= {16'h0000, data_hi};
        `CRC_OFS_RES_LO:  s_axi_rdata <= {16'h0000, crc_value[15:0]};
        `CRC_OFS_RES_HI:  s_axi_rdata <= {16'h0000, crc_value[31:16]};
        default:          s_axi_rdata <= 32'h00000000;
      endcase
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid || s_axi_rready ? !s_axi_arready && !s_axi_rvalid : 1'b0;
    end
  end

  // ==========================================================
  // Control register, kept when module is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_module_on     <= 1'b0;
      idle_halt_select  <= 1'b0;
      irq_source_select <= 1'b0;
      lsb_first_select  <= 1'b0;
    end else if (wr_fire && wr_addr == `CRC_OFS_CONTROL) begin
      crc_module_on     <= ctl_new[`CRC_BIT_ON];
      idle_halt_select  <= ctl_new[`CRC_BIT_IDLE];
      irq_source_select <= ctl_new[`CRC_BIT_ISEL];
      lsb_first_select  <= ctl_new[`CRC_BIT_LSB];
    end
  end

  // Run bit: software write wins over hardware clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shifter_run <= 1'b0;
    end else if (wr_fire && wr_addr == `CRC_OFS_CONTROL && wr_strb[0]) begin
      shifter_run <= ctl_new[`CRC_BIT_RUN];
    end else if (done_evt) begin
      shifter_run <= 1'b0;
    end
  end

  // Width, length and taps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      datum_width_minus1 <= 5'h00;
      poly_length_minus1 <= 5'h00;
      taps_low  <= 15'h0000;
      taps_high <= 16'h0000;
    end else if (wr_fire) begin
      case (wr_addr)
        `CRC_OFS_WIDTH: begin
          if (wr_strb[1]) datum_width_minus1 <= half_new[`CRC_POS_DWIDTH +: 5];
          if (wr_strb[0]) poly_length_minus1 <= half_new[`CRC_POS_PLEN +: 5];
        end
        `CRC_OFS_TAPS_LO: taps_low  <= {wr_strb[1] ? half_new[15:8] : taps_low[15:8],
                                        wr_strb[0] ? half_new[7:1] : taps_low[7:1]};
        `CRC_OFS_TAPS_HI: taps_high <= merge16(taps_high, half_new, wr_strb[1:0]);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Input data halves, cleared when off
  always_ff @(posedge aclk) begin
    if (!aresetn || !crc_module_on) begin
      data_lo <= 16'h0000;
      data_hi <= 16'h0000;
    end else if (wr_fire && wr_addr == `CRC_OFS_DATA_LO) begin
      data_lo <= merge16(data_lo, half_new, wr_strb[1:0]);
    end else if (wr_fire && wr_addr == `CRC_OFS_DATA_HI) begin
      data_hi <= merge16(data_hi, half_new, wr_strb[1:0]);
    end
  end

  // FIFO storage
  always_ff @(posedge aclk) begin
    if (push_ok) begin
      fifo_mem[wr_ptr] <= push_word;
    end
  end

  // FIFO pointers and word count
  always_ff @(posedge aclk) begin
    if (!aresetn || !crc_module_on) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      fifo_word_count <= 5'h00;
    end else begin
      if (push_ok) wr_ptr <= wr_ptr + 4'h1;
      if (pop) rd_ptr <= rd_ptr + 4'h1;
      case ({push_ok, pop})
        2'b10:   fifo_word_count <= fifo_word_count + 5'h01;
        2'b01:   fifo_word_count <= fifo_word_count - 5'h01;
        default: fifo_word_count <= fifo_word_count;
      endcase
    end
  end

  // Completion tracking
  always_ff @(posedge aclk) begin
    if (!aresetn || !crc_module_on) begin
      worked <= 1'b0;
    end else if (pop) begin
      worked <= 1'b1;
    end else if (done_evt) begin
      worked <= 1'b0;
    end
  end

  // Interrupt pulse per selected source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_irq <= 1'b0;
    end else begin
      crc_irq <= (irq_source_select && pop && !push_ok && fifo_word_count == 5'h01)
              || (!irq_source_select && done_evt);
    end
  end

  // ==========================================================
  // Shift engine
  crc_shift_engine u_engine (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clear     (!crc_module_on),
    .cfg       (cfg),
    .load      (pop),
    .load_word (fifo_mem[rd_ptr]),
    .step_en   (shifter_run && !halted),
    .seed_we   (seed_we),
    .seed_half (half_new),
    .busy      (eng_busy),
    .crc_value (crc_value)
  );

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_off_clears;
    !crc_module_on |=> fifo_word_count == 5'h00 && data_lo == 16'h0000 && crc_value == 32'h0;
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("off did not clear state");

  property p_idle_halt;
    halted |-> !pop;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("pop while halted in Idle");

  property p_count_up;
    crc_module_on && push_ok && !pop |=> fifo_word_count == $past(fifo_word_count) + 5'h01;
  endproperty
  a_count_up: assert property (p_count_up) else $error("word count missed a push");

  property p_limit;
    push_ok |-> fifo_word_count < fifo_limit(poly_length_minus1);
  endproperty
  a_limit: assert property (p_limit) else $error("push beyond FIFO limit");

  property p_start;
    pop |-> shifter_run && fifo_word_count != 5'h00;
  endproperty
  a_start: assert property (p_start) else $error("shift without run or words");

  property p_irq_empty;
    irq_source_select && pop && !push_ok && fifo_word_count == 5'h01 |=> crc_irq;
  endproperty
  a_irq_empty: assert property (p_irq_empty) else $error("no interrupt on empty");

  property p_irq_done;
    !irq_source_select && done_evt |=> crc_irq;
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("no interrupt on completion");

  property p_run_clear;
    done_evt && !(wr_fire && wr_addr == `CRC_OFS_CONTROL) |=> !shifter_run ##1 !worked;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run not cleared at end");

  property p_zero_term;
    cfg.poly[0];
  endproperty
  a_zero_term: assert property (p_zero_term) else $error("zero term not XORed");
endmodule : crc_regs
`default_nettype wire

// ===== inc/crc_map.svh
// Register map, field positions and reset values of the CRC engine.
// Assumes a 32-bit AXI4-Lite slave with byte addresses.
`ifndef CRC_MAP_SVH
`define CRC_MAP_SVH
`define CRC_ADDR_W       8
`define CRC_OFS_CONTROL  8'h00
`define CRC_OFS_WIDTH    8'h04
`define CRC_OFS_TAPS_LO  8'h08
`define CRC_OFS_TAPS_HI  8'h0C
`define CRC_OFS_DATA_LO  8'h10
`define CRC_OFS_DATA_HI  8'h14
`define CRC_OFS_RES_LO   8'h18
`define CRC_OFS_RES_HI   8'h1C
`define CRC_BIT_ON       15
`define CRC_BIT_IDLE     13
`define CRC_POS_COUNT    8
`define CRC_BIT_FULL     7
`define CRC_BIT_EMPTY    6
`define CRC_BIT_ISEL     5
`define CRC_BIT_RUN      4
`define CRC_BIT_LSB      3
`define CRC_POS_DWIDTH   8
`define CRC_POS_PLEN     0
`define CRC_CONTROL_RST  16'h0040
`define CRC_SMALL_PLEN   5'h07
`define CRC_LIMIT_SMALL  5'h10
`define CRC_LIMIT_LARGE  5'h08
`define CRC_HALF_MSB     5'h0F
`define CRC_RESP_OKAY    2'h0
`define CRC_RESP_SLVERR  2'h2
`endif

// ===== inc/crc_pkg.sv
// Types shared by the CRC register block and its shift engine.
// Assumes nothing beyond the map header.
package crc_pkg;
  // Engine configuration carried as one bundle
  typedef struct packed {
    logic        lsb_first;    // Shift LSb first
    logic [4:0]  width_m1;     // Datum width minus one
    logic [4:0]  plen_m1;      // Polynomial length minus one
    logic [31:0] poly;         // Tap enables, bit 0 forced
  } crc_cfg_t;
  // Shift engine states
  typedef enum logic {
    ENG_IDLE  = 1'b0,
    ENG_SHIFT = 1'b1
  } eng_state_t;
endpackage : crc_pkg

// ===== design/crc_shift_engine.sv
// Serial CRC shift engine, two data bits per clock.
// Assumes the register block loads one word while idle.
`timescale 1ns/1ps
`default_nettype none
module crc_shift_engine (
  input  wire logic             aclk,       // Clock
  input  wire logic             aresetn,    // Sync reset, low
  input  wire logic             clear,      // Soft reset
  input  wire crc_pkg::crc_cfg_t cfg,       // Configuration
  input  wire logic             load,       // Take load_word
  input  wire logic [31:0]      load_word,  // Datum from FIFO
  input  wire logic             step_en,    // Shifting allowed
  input  wire logic [1:0]       seed_we,    // Result half writes
  input  wire logic [15:0]      seed_half,  // Result half data
  output logic                  busy,       // Buffer still shifting
  output logic [31:0]           crc_value   // Running result
);
  crc_pkg::eng_state_t state;  // Engine state
  logic [31:0] shreg;          // Shift buffer
  logic [5:0]  remain;         // Bits left in buffer
  logic        bit_a;          // First bit this cycle
  logic        bit_b;          // Second bit this cycle
  logic [31:0] crc_one;        // After one bit
  logic [31:0] crc_two;        // After two bits

  // One CRC bit step, length-masked
  function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic d,
                                          input crc_pkg::crc_cfg_t f);
    logic [31:0] mask;
    logic        fb;
    mask = 32'hFFFFFFFF >> (5'h1F - f.plen_m1);
    fb   = d ^ c[f.plen_m1];
    crc_bit = (c << 1) & mask;
    if (fb) begin
      crc_bit = crc_bit ^ (f.poly & mask);
    end
  endfunction : crc_bit

  // Bit pick per direction
  always_comb begin
    bit_a   = cfg.lsb_first ? shreg[0] : shreg[31];
    bit_b   = cfg.lsb_first ? shreg[1] : shreg[30];
    crc_one = crc_bit(crc_value, bit_a, cfg);
    crc_two = crc_bit(crc_one, bit_b, cfg);
  end

  // ==========================================================
  // Buffer and state
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      state  <= crc_pkg::ENG_IDLE;
      shreg  <= 32'h00000000;
      remain <= 6'h00;
    end else if (load) begin
      state  <= crc_pkg::ENG_SHIFT;
      shreg  <= cfg.lsb_first ? load_word : (load_word << (5'h1F - cfg.width_m1));
      remain <= {1'b0, cfg.width_m1} + 6'h01;
    end else begin
      case (state)
        crc_pkg::ENG_SHIFT: begin
          if (step_en) begin
            shreg  <= cfg.lsb_first ? (shreg >> 2) : (shreg << 2);
            remain <= (remain > 6'h02) ? remain - 6'h02 : 6'h00;
            if (remain <= 6'h02) begin
              state <= crc_pkg::ENG_IDLE;
            end
          end
        end
        default: state <= crc_pkg::ENG_IDLE;
      endcase
    end
  end

  // Result register, seed writes win
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      crc_value <= 32'h00000000;
    end else if (seed_we != 2'h0) begin
      if (seed_we[0]) crc_value[15:0] <= seed_half;
      if (seed_we[1]) crc_value[31:16] <= seed_half;
    end else if (state == crc_pkg::ENG_SHIFT && step_en) begin
      crc_value <= (remain >= 6'h02) ? crc_two : crc_one;
    end
  end

  assign busy = (state == crc_pkg::ENG_SHIFT);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_two_bits;
    busy && step_en && !load && !clear && remain > 6'h02 |=> remain == $past(remain) - 6'h02;
  endproperty
  a_two_bits: assert property (p_two_bits) else $error("engine not two bits per clock");
endmodule : crc_shift_engine
`default_nettype wire

// ===== sim/tb_top.sv
// Bench for the CRC register block: AXI4-Lite master tasks, scenarios.
// Assumes crc_regs and its map header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "crc_map.svh"
module tb_top;
  // ==========
  // Signals
  logic        aclk = 1'b0, aresetn = 1'b0, idle_mode = 1'b0; // Clock, reset, idle
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0; // Handshakes
  logic [7:0]  aw = 8'h00, ar = 8'h00; // Addresses
  logic [31:0] wd = 32'h0, rdata;      // Data
  logic        awr, wrd, bv, arr, rv, irq; // Design answers
  logic [1:0]  br, rr, last_br;        // Responses, last write response
  int          errors, tests_run, irq_cnt; // Counters
  crc_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .idle_mode(idle_mode),
    .crc_irq(irq));
  initial forever #5 aclk = ~aclk;
  // Count interrupt pulses
  always @(posedge aclk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  // ==========
  // Bus and check tasks
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    aw  <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      n++;
    end while (bv !== 1'b1 && n < 99);
    last_br = br;
    bre <= 1'b0;
    if (n >= 99) begin
      errors++;
      finish_test();
    end
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string s);
    int n;
    n = 0;
    @(posedge aclk);
    ar  <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      n++;
    end while (rv !== 1'b1 && n < 99);
    rre <= 1'b0;
    if (n >= 99) begin
      errors++;
      finish_test();
    end
    chk(s, e, (s == "resp") ? 32'(rr) : rdata);
  endtask : rc
  task automatic wirq(input int want);
    int n;
    for (n = 0; n < 300 && irq_cnt != want; n++) @(posedge aclk);
    chk("irq_count", want, irq_cnt);
    if (irq_cnt != want) finish_test();
  endtask : wirq
  // ==========
  // Scenarios
  task automatic t_crc(input logic [31:0] ctl, input logic [31:0] e);
    int c;
    wr(`CRC_OFS_CONTROL, 32'h0);
    wr(`CRC_OFS_WIDTH, 32'h707);
    wr(`CRC_OFS_TAPS_LO, 32'h6);
    wr(`CRC_OFS_CONTROL, ctl);
    c = irq_cnt;
    wr(`CRC_OFS_DATA_LO, 32'h80);
    wirq(c + 1);
    rc(`CRC_OFS_RES_LO, e, "result");
    rc(`CRC_OFS_CONTROL, ctl & 32'hFFEF | 32'h40, "control_done");
    $display("crc test done");
  endtask : t_crc
  task automatic t_flow;
    int c;
    wr(`CRC_OFS_CONTROL, 32'h8000);
    c = irq_cnt;
    wr(`CRC_OFS_DATA_LO, 32'h5A);
    repeat (20) @(posedge aclk);
    rc(`CRC_OFS_CONTROL, 32'h8100, "control_stopped");
    idle_mode <= 1'b1;
    wr(`CRC_OFS_CONTROL, 32'hA030);
    repeat (20) @(posedge aclk);
    rc(`CRC_OFS_CONTROL, 32'hA130, "control_halted");
    chk("irq_quiet", c, irq_cnt);
    idle_mode <= 1'b0;
    wirq(c + 1);
    $display("flow test done");
  endtask : t_flow
  task automatic t_fill;
    wr(`CRC_OFS_CONTROL, 32'h0);
    rc(`CRC_OFS_RES_LO, 32'h0, "result_off");
    wr(`CRC_OFS_CONTROL, 32'h8000);
    for (int i = 0; i < 17; i++) wr(`CRC_OFS_DATA_LO, 32'(i));
    rc(`CRC_OFS_CONTROL, 32'h9080, "full16");
    wr(`CRC_OFS_CONTROL, 32'h0);
    rc(`CRC_OFS_CONTROL, 32'h40, "control_off");
    wr(`CRC_OFS_WIDTH, 32'h708);
    wr(`CRC_OFS_CONTROL, 32'h8000);
    for (int i = 0; i < 9; i++) wr(`CRC_OFS_DATA_LO, 32'(i));
    rc(`CRC_OFS_CONTROL, 32'h8880, "full8");
    $display("fill test done");
  endtask : t_fill
  // Wide datum pushed on the high half, seed readback
  task automatic t_wide;
    int c;
    wr(`CRC_OFS_CONTROL, 32'h0);
    wr(`CRC_OFS_WIDTH, 32'h1107);
    wr(`CRC_OFS_CONTROL, 32'h8010);
    wr(`CRC_OFS_RES_HI, 32'h1234);
    rc(`CRC_OFS_RES_HI, 32'h1234, "seed_high");
    c = irq_cnt;
    wr(`CRC_OFS_DATA_LO, 32'h0);
    rc(`CRC_OFS_CONTROL, 32'h8050, "count_low_half");
    wr(`CRC_OFS_DATA_HI, 32'h2);
    wirq(c + 1);
    rc(`CRC_OFS_RES_LO, 32'hD6, "result_wide");
    $display("wide test done");
  endtask : t_wide
  // Register access, unused bits and responses
  task automatic t_regs;
    rc(`CRC_OFS_CONTROL, 32'h40, "control_reset");
    wr(`CRC_OFS_TAPS_LO, 32'hFFFFFFFF);
    chk("bresp_okay", 32'(`CRC_RESP_OKAY), 32'(last_br));
    rc(`CRC_OFS_TAPS_LO, 32'hFFFE, "taps_low");
    wr(`CRC_OFS_TAPS_HI, 32'hFFFFFFFF);
    rc(`CRC_OFS_TAPS_HI, 32'hFFFF, "taps_high");
    wr(`CRC_OFS_WIDTH, 32'hFFFFFFFF);
    rc(`CRC_OFS_WIDTH, 32'h1F1F, "width");
    wr(`CRC_OFS_CONTROL, 32'h4007);
    rc(`CRC_OFS_CONTROL, 32'h40, "control_unused");
    wr(`CRC_OFS_TAPS_HI, 32'h0);
    wr(8'h22, 32'hFFFFFFFF);
    chk("bresp_unmapped", 32'(`CRC_RESP_SLVERR), 32'(last_br));
    rc(8'h22, 32'(`CRC_RESP_SLVERR), "resp");
    $display("register test done");
  endtask : t_regs
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_crc(32'h8010, 32'h89);
    t_crc(32'h8018, 32'h07);
    t_flow();
    t_fill();
    t_wide();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
